// [rtl/elapsed_time_counter.sv]
// elapsed time capture counter: 40-bit timestamp with capture lock
// assumes vco tick inputs are pulses on ref_clk; pins are asynchronous
`timescale 1ns/1ns
`include "elapsed_time_counter_cfg.svh"

// Contract
// - capture from pin edge or select fall
// - capture copies count into 40-bit field
// - count clock is pll3/8 or pll2/20
// - vco select 0 pll3, 1 pll2
// - trigger select 1 pin, 0 serial
// - enable low holds counter at zero
// - serial fall captures unless locked; code also ignores it while enable is low
// - msb read locks serial until lsb read
// - capture and re-arm within one read
// - pin function 0x27 makes pin trigger
// - pin capture locks until lsb read
// - counter counts up and wraps
// - field read as five bytes msb first
// - clear zero means normal counting
// - vco select also drives reference validation
// - absolute time less accurate than difference
// - polarity 0 rising, 1 falling
module elapsed_time_counter (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   pll3_vco_tick,
    input  wire logic                   pll2_vco_tick,
    input  wire logic                   count_clock_vco_select,
    input  wire logic                   counter_run_enable,
    input  wire logic                   counter_clear,
    input  wire logic                   capture_trigger_select,
    input  wire logic [5:0]             pin_function_select,
    input  wire logic                   pin_polarity_invert,
    input  wire logic                   trigger_pin,
    input  wire logic                   serial_chip_select_n,
    input  wire logic                   byte_read_strobe,
    input  wire logic [2:0]             byte_read_index,
    output logic      [7:0]             byte_read_data,
    output logic      [`ETC_CNT_W-1:0]  captured_count_field,
    output logic                        capture_locked,
    output logic                        validation_vco_select,
    output logic                        count_tick
);

    // three-stage synchronisers for the asynchronous pins
    logic [2:0] pin_sync_r;
    logic [2:0] pin_sync_nxt;
    logic [2:0] cs_sync_r;
    logic [2:0] cs_sync_nxt;
    logic       pin_lvl_r;
    logic       pin_lvl_nxt;
    logic       cs_lvl_r;
    logic       cs_lvl_nxt;

    always_comb begin
        pin_sync_nxt = {pin_sync_r[1:0], trigger_pin};
        cs_sync_nxt  = {cs_sync_r[1:0], serial_chip_select_n};
        pin_lvl_nxt  = pin_lvl_r;
        cs_lvl_nxt   = cs_lvl_r;
        if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_lvl_nxt = pin_sync_r[2];
        end
        if (cs_sync_r[1] == cs_sync_r[2]) begin
            cs_lvl_nxt = cs_sync_r[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_sync_r <= 3'h0;
            cs_sync_r  <= 3'h7;
            pin_lvl_r  <= 1'b0;
            cs_lvl_r   <= 1'b1;
        end else begin
            pin_sync_r <= pin_sync_nxt;
            cs_sync_r  <= cs_sync_nxt;
            pin_lvl_r  <= pin_lvl_nxt;
            cs_lvl_r   <= cs_lvl_nxt;
        end
    end

    // active-level pin after polarity, and edge events
    logic pin_active;
    logic pin_active_prev_r;
    logic pin_event;
    logic cs_fall;
    logic cs_rise;
    logic cs_prev_r;

    assign pin_active = pin_lvl_r ^ pin_polarity_invert;
    assign pin_event  = pin_active & ~pin_active_prev_r
                      & (pin_function_select == `ETC_PIN_CAPTURE);
    assign cs_fall    = cs_prev_r & ~cs_lvl_r;
    assign cs_rise    = ~cs_prev_r & cs_lvl_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // seen as already active so a pin held active with polarity 1 is no edge
            pin_active_prev_r <= 1'b1;
            cs_prev_r         <= 1'b1;
        end else begin
            pin_active_prev_r <= pin_active;
            cs_prev_r         <= cs_lvl_r;
        end
    end

    // count clock dividers
    logic [`ETC_DIV_W-1:0] div3_r;
    logic [`ETC_DIV_W-1:0] div3_nxt;
    logic [`ETC_DIV_W-1:0] div2_r;
    logic [`ETC_DIV_W-1:0] div2_nxt;
    logic                  tick3;
    logic                  tick2;

    function automatic logic [`ETC_DIV_W-1:0] div_step(
        input logic [`ETC_DIV_W-1:0] cur,
        input logic                  tick,
        input int                    ratio
    );
        logic [`ETC_DIV_W-1:0] last;
        last = `ETC_DIV_W'(ratio - 1);
        if (!tick) begin
            div_step = cur;
        end else if (cur == last) begin
            div_step = '0;
        end else begin
            div_step = cur + `ETC_DIV_W'(1);
        end
    endfunction

    assign tick3 = pll3_vco_tick
                 & (div3_r == `ETC_DIV_W'(`ETC_PLL3_DIV - 1));
    assign tick2 = pll2_vco_tick
                 & (div2_r == `ETC_DIV_W'(`ETC_PLL2_DIV - 1));
    assign count_tick = (count_clock_vco_select == `ETC_SEL_PLL2)
                      ? tick2 : tick3;
    assign validation_vco_select = count_clock_vco_select;

    always_comb begin
        div3_nxt = div_step(div3_r, pll3_vco_tick, `ETC_PLL3_DIV);
        div2_nxt = div_step(div2_r, pll2_vco_tick, `ETC_PLL2_DIV);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div3_r <= '0;
            div2_r <= '0;
        end else begin
            div3_r <= div3_nxt;
            div2_r <= div2_nxt;
        end
    end

    // running counter
    elapsed_time_counter_pkg::count_t count_r;
    elapsed_time_counter_pkg::count_t count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (!counter_run_enable || counter_clear) begin
            count_nxt = '0;
        end else if (count_tick) begin
            count_nxt = count_r + `ETC_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // capture lock and holding field
    elapsed_time_counter_pkg::arm_state_t state_r;
    elapsed_time_counter_pkg::arm_state_t state_nxt;
    elapsed_time_counter_pkg::count_t     hold_r;
    elapsed_time_counter_pkg::count_t     hold_nxt;
    logic                                 msb_seen_r;
    logic                                 msb_seen_nxt;
    logic                                 trig_event;
    logic                                 lsb_read;
    logic                                 msb_read;

    assign lsb_read = byte_read_strobe
                    & (byte_read_index == `ETC_BYTE_LSB);
    assign msb_read = byte_read_strobe
                    & (byte_read_index == `ETC_BYTE_MSB);
    assign trig_event = counter_run_enable &
        ((capture_trigger_select == `ETC_TRIG_PIN) ? pin_event
                                                   : cs_fall);

    always_comb begin
        state_nxt    = state_r;
        hold_nxt     = hold_r;
        msb_seen_nxt = msb_seen_r;
        case (state_r)
            elapsed_time_counter_pkg::ARMED: begin
                if (trig_event) begin
                    hold_nxt = count_r;
                    if (capture_trigger_select == `ETC_TRIG_PIN) begin
                        state_nxt = elapsed_time_counter_pkg::LOCK_PIN;
                    end
                end
                if (msb_read
                    && capture_trigger_select == `ETC_TRIG_SERIAL) begin
                    msb_seen_nxt = 1'b1;
                end
                // lock takes hold once the msb-reading transaction ends
                if ((msb_seen_r || msb_read) && cs_rise && !lsb_read) begin
                    state_nxt    = elapsed_time_counter_pkg::LOCK_SERIAL;
                    msb_seen_nxt = 1'b0;
                end
                if (lsb_read) begin
                    msb_seen_nxt = 1'b0;
                end
            end
            elapsed_time_counter_pkg::LOCK_SERIAL,
            elapsed_time_counter_pkg::LOCK_PIN: begin
                if (lsb_read) begin
                    state_nxt = elapsed_time_counter_pkg::ARMED;
                end
            end
            default: begin
                state_nxt = elapsed_time_counter_pkg::ARMED;
            end
        endcase
        if (!counter_run_enable) begin
            msb_seen_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r    <= elapsed_time_counter_pkg::ARMED;
            hold_r     <= '0;
            msb_seen_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            hold_r     <= hold_nxt;
            msb_seen_r <= msb_seen_nxt;
        end
    end

    // byte readback, msb at index 4
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (byte_read_strobe) begin
            case (byte_read_index)
                3'h0: rdata_nxt = hold_r[7:0];
                3'h1: rdata_nxt = hold_r[15:8];
                3'h2: rdata_nxt = hold_r[23:16];
                3'h3: rdata_nxt = hold_r[31:24];
                3'h4: rdata_nxt = hold_r[39:32];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign byte_read_data       = rdata_r;
    assign captured_count_field = hold_r;
    assign capture_locked = (state_r != elapsed_time_counter_pkg::ARMED);

    // checks
    hold_when_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !counter_run_enable |=> count_r == '0)
        else $error("counter not held at zero while disabled");
    clear_holds_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        counter_run_enable && counter_clear |=> count_r == '0)
        else $error("clear did not zero the counter");
    count_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        counter_run_enable && !counter_clear && count_tick
        |=> count_r == $past(count_r) + `ETC_CNT_W'(1))
        else $error("counter did not step on tick");
    capture_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_locked && trig_event |=> hold_r == $past(count_r))
        else $error("capture did not copy the count");
    locked_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture_locked |=> hold_r == $past(hold_r))
        else $error("holding field changed while locked");
    pin_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_locked && trig_event && capture_trigger_select
        |=> capture_locked)
        else $error("pin capture did not lock");
    lsb_rearm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture_locked && lsb_read |=> !capture_locked)
        else $error("lsb read did not re-arm");
    serial_no_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_locked && !capture_trigger_select && !msb_read
        && !msb_seen_r |=> !capture_locked)
        else $error("serial capture locked without msb read");
    div3_tick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick3 |=> div3_r == '0)
        else $error("pll3 divider did not wrap after tick");

    cap_pin_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == elapsed_time_counter_pkg::LOCK_PIN ##[1:50] lsb_read);
    cap_serial_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == elapsed_time_counter_pkg::LOCK_SERIAL);
    wrap_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        count_tick && count_r == '1);

endmodule

// [rtl/elapsed_time_counter_cfg.svh]
// constants for the elapsed time capture counter
// assumes inclusion by the counter package, design file and bench
`ifndef ELAPSED_TIME_COUNTER_CFG_SVH
`define ELAPSED_TIME_COUNTER_CFG_SVH

`define ETC_CNT_W          40
`define ETC_PLL3_DIV       8
`define ETC_PLL2_DIV       20
`define ETC_DIV_W          5
`define ETC_PIN_FUNC_W     6
`define ETC_PIN_CAPTURE    6'h27
`define ETC_SEL_PLL3       1'b0
`define ETC_SEL_PLL2       1'b1
`define ETC_TRIG_SERIAL    1'b0
`define ETC_TRIG_PIN       1'b1
`define ETC_BYTE_MSB       3'h4
`define ETC_BYTE_LSB       3'h0

`endif

// [rtl/elapsed_time_counter_pkg.sv]
// types for the elapsed time capture counter
// assumes the cfg header sits beside it
`include "elapsed_time_counter_cfg.svh"
package elapsed_time_counter_pkg;
    typedef logic [`ETC_CNT_W-1:0] count_t;
    typedef enum logic [1:0] {
        ARMED,
        LOCK_SERIAL,
        LOCK_PIN
    } arm_state_t;
endpackage

// [verif/host_model.sv]
// serial host and trigger pin source facing the capture counter
// assumes ref_clk of the counter and its byte read port
`timescale 1ns/1ns
module host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] byte_read_data,
    output logic            trigger_pin,
    output logic            serial_chip_select_n,
    output logic            byte_read_strobe,
    output logic [2:0]      byte_read_index
);
    initial begin
        trigger_pin = 1'b0;
        serial_chip_select_n = 1'b1;
        byte_read_strobe = 1'b0;
        byte_read_index = 3'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cs(input logic v);
        step(1);
        serial_chip_select_n = v;
    endtask
    // levels held whole cycles, far beyond the minimum high time
    task automatic pin(input logic v);
        step(1);
        trigger_pin = v;
    endtask
    task automatic rd(input logic [2:0] idx, output logic [7:0] d);
        step(1);
        byte_read_strobe = 1'b1;
        byte_read_index = idx;
        step(1);
        byte_read_strobe = 1'b0;
        byte_read_index = ~idx;
        d = byte_read_data;
    endtask
    // quiet time after the re-arming read, over 1us
    task automatic settle();
        step(26);
    endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the elapsed time capture counter
// assumes the cfg header on the include path
`timescale 1ns/1ns
`include "elapsed_time_counter_cfg.svh"
module tb;
    logic        ref_clk;
    logic        sys_rst;
    logic        pll3_vco_tick;
    logic        pll2_vco_tick;
    logic        vsel;
    logic        en;
    logic        clr;
    logic        tsel;
    logic [5:0]  pfun;
    logic        pinv;
    logic        trigger_pin;
    logic        serial_chip_select_n;
    logic        byte_read_strobe;
    logic [2:0]  byte_read_index;
    logic [7:0]  byte_read_data;
    logic [39:0] captured_count_field;
    logic        capture_locked;
    logic        validation_vco_select;
    logic        count_tick;
    logic [39:0] f0;
    logic [7:0]  d;
    int          fail_count;
    int          tests_run;

    elapsed_time_counter u_elapsed_time_counter (
        .ref_clk               (ref_clk),
        .sys_rst               (sys_rst),
        .pll3_vco_tick         (pll3_vco_tick),
        .pll2_vco_tick         (pll2_vco_tick),
        .count_clock_vco_select(vsel),
        .counter_run_enable    (en),
        .counter_clear         (clr),
        .capture_trigger_select(tsel),
        .pin_function_select   (pfun),
        .pin_polarity_invert   (pinv),
        .trigger_pin           (trigger_pin),
        .serial_chip_select_n  (serial_chip_select_n),
        .byte_read_strobe      (byte_read_strobe),
        .byte_read_index       (byte_read_index),
        .byte_read_data        (byte_read_data),
        .captured_count_field  (captured_count_field),
        .capture_locked        (capture_locked),
        .validation_vco_select (validation_vco_select),
        .count_tick            (count_tick)
    );
    host_model u_host_model (
        .ref_clk               (ref_clk),
        .byte_read_data        (byte_read_data),
        .trigger_pin           (trigger_pin),
        .serial_chip_select_n  (serial_chip_select_n),
        .byte_read_strobe      (byte_read_strobe),
        .byte_read_index       (byte_read_index)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) pll2_vco_tick <= ~pll2_vco_tick;

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // count span in pll3/8 ticks; two periods of slack, no wrap here
    task automatic near(input logic [39:0] got, input time t0);
        longint e;
        e = ($time - t0) / 320;
        check(40'(got + 2 >= e && got <= e + 2), 40'h1);
    endtask
    task automatic grab();
        u_host_model.cs(1'b0);
        u_host_model.step(8);
    endtask
    task automatic done();
        u_host_model.cs(1'b1);
        u_host_model.step(8);
    endtask

    task automatic t_ticks();
        int n;
        for (int s = 0; s < 2; s++) begin
            vsel = s[0];
            u_host_model.step(45);
            check(validation_vco_select, vsel);
            n = 0;
            while (count_tick !== 1'b1 && n < 100) begin
                u_host_model.step(1);
                n++;
            end
            n = 0;
            do begin
                u_host_model.step(1);
                n++;
            end while (count_tick !== 1'b1 && n < 100);
            check(40'(n), s ? 40'h28 : 40'h8);
        end
        vsel = `ETC_SEL_PLL3;
        // halted vco ticks must stop the count clock
        pll3_vco_tick = 1'b0;
        n = 0;
        repeat (20) begin
            u_host_model.step(1);
            if (count_tick !== 1'b0) n++;
        end
        check(40'(n), 40'h0);
        pll3_vco_tick = 1'b1;
    endtask

    task automatic t_serial();
        logic [39:0] v;
        time         t0;
        grab();
        t0 = $time;
        f0 = captured_count_field;
        u_host_model.rd(`ETC_BYTE_MSB, d);
        done();
        check(capture_locked, 40'h1);
        grab();
        check(captured_count_field, f0);
        u_host_model.rd(`ETC_BYTE_LSB, d);
        check(d, f0[7:0]);
        done();
        check(capture_locked, 40'h0);
        u_host_model.pin(1'b1);
        u_host_model.step(8);
        check(captured_count_field, f0);
        u_host_model.pin(1'b0);
        grab();
        near(captured_count_field - f0, t0);
        for (int i = 4; i >= 0; i--) begin
            u_host_model.rd(i[2:0], d);
            v = {v[31:0], d};
        end
        check(v, captured_count_field);
        u_host_model.rd(3'h5, d);
        check(d, 40'h0);
        done();
        check(capture_locked, 40'h0);
    endtask

    task automatic t_pin();
        for (int p = 0; p < 2; p++) begin
            tsel = `ETC_TRIG_PIN;
            pinv = p[0];
            u_host_model.pin(p[0]);
            u_host_model.step(8);
            pfun = `ETC_PIN_CAPTURE;
            u_host_model.step(8);
            f0 = captured_count_field;
            grab();
            done();
            check(captured_count_field, f0);
            u_host_model.pin(~p[0]);
            u_host_model.step(8);
            check(capture_locked, 40'h1);
            check(40'(captured_count_field == f0), 40'h0);
            f0 = captured_count_field;
            u_host_model.pin(p[0]);
            u_host_model.step(8);
            u_host_model.pin(~p[0]);
            u_host_model.step(8);
            check(captured_count_field, f0);
            u_host_model.rd(`ETC_BYTE_LSB, d);
            u_host_model.step(1);
            check(capture_locked, 40'h0);
            u_host_model.settle();
            u_host_model.pin(p[0]);
            u_host_model.step(8);
            check(captured_count_field, f0);
            pfun = 6'h26;
            u_host_model.pin(~p[0]);
            u_host_model.step(8);
            check(captured_count_field, f0);
        end
        tsel = `ETC_TRIG_SERIAL;
    endtask

    // pin stays still around every enable change
    task automatic t_zero();
        time t0;
        en = 1'b0;
        u_host_model.step(20);
        f0 = captured_count_field;
        grab();
        check(captured_count_field, f0);
        done();
        en = 1'b1;
        t0 = $time;
        u_host_model.step(100);
        grab();
        near(captured_count_field, t0);
        done();
        clr = 1'b1;
        u_host_model.step(20);
        grab();
        check(captured_count_field, 40'h0);
        done();
        clr = 1'b0;
        t0 = $time;
        u_host_model.step(60);
        grab();
        near(captured_count_field, t0);
        done();
    endtask

    initial begin
        #400000;
        fail_count++;
        conclude();
    end
    initial begin
        fail_count = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        pll2_vco_tick = 1'b0;
        pll3_vco_tick = 1'b1;
        vsel = `ETC_SEL_PLL3;
        en = 1'b1;
        clr = 1'b0;
        tsel = `ETC_TRIG_SERIAL;
        pfun = `ETC_PIN_CAPTURE;
        pinv = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        u_host_model.step(6);
        t_ticks();
        t_serial();
        t_pin();
        t_zero();
        conclude();
    end
endmodule
